// file: bench/flm_link_properties.sv
`timescale 1ns/100ps
module flm_link_properties import flm_pkg::*; (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// link signals
	input wire logic link_clk,
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_addr,
	input wire logic p_up_valid,
	input wire logic [1:0] p_up_kind,
	input wire logic [31:0] p_up_data,
	input wire logic s_up_valid,
	input wire logic [31:0] s_up_data
);
	// single domain, so one default clock and reset for all
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// divider phases, four cycles each
	sequence s_hi; link_clk [*3] ##1 !link_clk; endsequence
	sequence s_lo; !link_clk [*3] ##1 link_clk; endsequence
	property p_clk_hi; $rose(link_clk) |=> s_hi; endproperty
	a_clk_hi: assert property (p_clk_hi) else $error("link clock high phase");
	property p_clk_lo; $fell(link_clk) |=> s_lo; endproperty
	a_clk_lo: assert property (p_clk_lo) else $error("link clock low phase");
	property p_cmd_hold; $rose(cmd_valid) |=> (cmd_valid && $stable(cmd_addr)) [*7]; endproperty
	a_cmd_hold: assert property (p_cmd_hold) else $error("command not held");
	property p_reply; $rose(cmd_valid) |-> ##[1:40] (p_up_valid && p_up_kind == KIND_REPLY); endproperty
	a_reply: assert property (p_reply) else $error("no reply on primary");
	property p_up_hold; $rose(p_up_valid) |=> (p_up_valid && $stable(p_up_data)) [*7]; endproperty
	a_up_hold: assert property (p_up_hold) else $error("upstream word not held");
	// the secondary only ever mirrors a primary science slot
	property p_sec_sci; s_up_valid |-> p_up_valid && p_up_kind == KIND_SCI; endproperty
	a_sec_sci: assert property (p_sec_sci) else $error("secondary outside science");
	property p_sec_slot; s_up_valid |-> s_up_data[31:16] == p_up_data[31:16]; endproperty
	a_sec_slot: assert property (p_sec_slot) else $error("slot index mismatch");
	property p_tc; p_up_valid && p_up_kind == KIND_TC |-> !s_up_valid && p_up_data[31:16] == 16'h0;
	endproperty
	a_tc: assert property (p_tc) else $error("bad end of image word");
endmodule

// file: bench/test_fee_link_mode_router.sv
`timescale 1ns/100ps
module test_fee_link_mode_router import flm_pkg::*;;
	logic aclk = 1'b0, aresetn = 1'b0, sync_in = 1'b0;
	logic [15:0] vid_a = 16'h0, vid_b = 16'h0, hires_adc = 16'h0;
	logic [11:0] std_adc = 12'h0;
	logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
	logic [31:0] s_axi_wdata = 32'h0, rdat, c0, ctl, exp_s;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp, op;
	logic [31:0] s_axi_rdata;
	logic analog_pwr_full, hires_excite, amp_zero;
	logic [2:0] conv_cfg, hires_sel;
	logic [3:0] std_sel;
	int fails = 0, compares = 0, i;
	// clock, 40 ns period
	always #20 aclk = ~aclk;
	flm_link_if lnk ();
	flm_fee_end #(.NUM_PIX(8), .FULL_LOAD_CYC_P(200)) i_flm_fee_end (.aclk, .aresetn, .lnk,
		.sync_in, .vid_a, .vid_b, .hires_adc, .std_adc, .analog_pwr_full, .conv_cfg,
		.hires_sel, .hires_excite, .amp_zero, .std_sel);
	flm_dpu_end i_flm_dpu_end (.aclk, .aresetn, .lnk, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq);
	flm_link_properties i_flm_link_properties (.aclk, .aresetn, .link_clk(lnk.link_clk),
		.cmd_valid(lnk.cmd_valid), .cmd_addr(lnk.cmd_addr), .p_up_valid(lnk.p_up_valid),
		.p_up_kind(lnk.p_up_kind), .p_up_data(lnk.p_up_data), .s_up_valid(lnk.s_up_valid),
		.s_up_data(lnk.s_up_data));
	// verdict, the single exit of the run
	task tally_and_finish;
		if (fails == 0 && compares > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [31:0] e, input logic [31:0] g, input string nm);
		compares++;
		if (g !== e) begin
			$display("FAIL %s expected %h seen %h", nm, e, g);
			fails++;
		end
	endtask
	// a spent wait bound is a mismatch
	task automatic guard(input int n);
		if (n >= 50) begin
			fails++;
			tally_and_finish();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge aclk);
		{s_axi_awaddr, s_axi_wdata} <= {a, d};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1 && n < 50);
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
		guard(n);
	endtask
	task automatic rd(input logic [7:0] a);
		int n = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1 && n < 50);
		{rdat, rsp} = {s_axi_rdata, s_axi_rresp};
		s_axi_rready <= 1'b0;
		guard(n);
	endtask
	// one link command, polled until the reply lands
	task automatic cmd(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		wr(R_WDATA, d);
		wr(R_CMD, {16'h0, a, 6'h0, w, 1'b1});
		for (n = 0; n < 50; n++) begin
			rd(R_STATUS);
			if (rdat[0] === 1'b0) break;
		end
		guard(n);
		rd(R_RDATA);
	endtask
	// long sync pulse, then a whole period for image and housekeeping
	task automatic frame;
		logic [3:0] s0;
		@(posedge aclk);
		sync_in <= 1'b1;
		repeat (300) @(posedge aclk);
		sync_in <= 1'b0;
		repeat (100) @(posedge aclk);
		chk(32'(op == OP_RUN), 32'(analog_pwr_full), "pwr");
		s0 = std_sel;
		repeat (250) @(posedge aclk);
		chk(32'(4'(s0 + 4'h1)), 32'(std_sel), "std_sel");
		chk(32'h2, 32'({amp_zero, hires_excite}), "zero");
		repeat (650) @(posedge aclk);
		chk(32'h8, 32'({amp_zero, hires_excite, hires_sel}), "meas0");
		repeat (3000) @(posedge aclk);
		chk(32'h9, 32'({amp_zero, hires_excite, hires_sel}), "meas1");
		repeat (2000) @(posedge aclk);
		chk(32'h0, 32'({analog_pwr_full, amp_zero, hires_excite}), "idle");
	endtask
	function automatic logic [15:0] nwords(input int m, input logic [1:0] o);
		nwords = o != OP_RUN ? 16'h0 : m == 5 ? 16'h8 : 16'h4;
	endfunction
	// converter setup {rate_4m, pingpong, dual} expected per mode
	function automatic logic [2:0] cfg_exp(input int m);
		cfg_exp = (m == 1 || m == 5) ? 3'h0 : (m == 2 || m == 6) ? 3'h7 : m == 7 ? 3'h6 : 3'h5;
	endfunction
	// main sequence: every mode running, then stop and self-test
	initial begin
		void'($urandom(32'hA017));
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		rd(8'h40);
		chk(RESP_SLVERR, rsp, "rresp");
		wr(8'h44, 32'h1);
		chk(RESP_SLVERR, rsp, "bresp");
		wr(R_IRQ_MASK, 32'h1);
		for (i = 0; i < 10; i++) begin
			op = i < 8 ? OP_RUN : 2'(i - 8);
			ctl = {27'h0, 3'(i), op};
			{vid_a, vid_b, hires_adc, std_adc} <= 60'({$urandom, $urandom});
			rd(R_PIX_CNT);
			c0 = rdat;
			cmd(1'b1, ADDR_CTRL, ctl);
			cmd(1'b0, ADDR_CTRL, 32'h0);
			chk(ctl, rdat, "ctrl");
			frame();
			cmd(1'b0, ADDR_HIRES, 32'h0);
			chk({16'h0, hires_adc}, rdat, "hires");
			cmd(1'b0, ADDR_STD | 8'($urandom_range(15)), 32'h0);
			chk({20'h0, std_adc}, rdat, "std");
			chk(32'(cfg_exp(i % 8)), 32'(conv_cfg), "cfg");
			rd(R_PIX_CNT);
			chk(c0 + 32'(nwords(i, op)), rdat, "count");
			if (op == OP_RUN) begin
				rd(R_PIX_P);
				chk({nwords(i, op) - 16'h1, i == 5 ? vid_b : vid_a}, rdat, "pri");
				if (i != 5) exp_s = {16'h3, vid_b};
				rd(R_PIX_S);
				chk(exp_s, rdat, "sec");
				chk(32'h1, 32'(irq), "irq");
				wr(R_IRQ_STAT, 32'h3);
			end
			chk(32'h0, 32'(irq), "irq_clr");
		end
		tally_and_finish();
	end
endmodule

// file: rtl/flm_dpu_end.sv
`timescale 1ns/100ps
module flm_dpu_end import flm_pkg::*; (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// link to front end
	flm_link_if.dpu lnk,
	// axi4-lite write
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// interrupt
	output logic irq
);
	// --------------------------------------------------------------
	// link clock divider
	// --------------------------------------------------------------
	logic [7:0] div_reg;
	logic rise_en, fall_en;
	assign rise_en = (div_reg == 8'(LINK_HALF - 1));
	assign fall_en = (div_reg == 8'(LINK_DIV - 1));

	// link paced from the common clock
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div_reg <= 8'h00;
			lnk.link_clk <= 1'b0;
		end else begin
			div_reg <= fall_en ? 8'h00 : div_reg + 8'h01;
			if (rise_en) begin
				lnk.link_clk <= 1'b1;
			end else if (fall_en) begin
				lnk.link_clk <= 1'b0;
			end
		end
	end

	// --------------------------------------------------------------
	// upstream receive, synchronised
	// --------------------------------------------------------------
	logic [67:0] up_m_reg, up_s_reg;
	logic pv_s, sv_s;
	logic [1:0] pk_s;
	logic [31:0] pd_s, sd_s;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			up_m_reg <= '0;
			up_s_reg <= '0;
		end else begin
			up_m_reg <= {lnk.p_up_valid, lnk.p_up_kind, lnk.p_up_data, lnk.s_up_valid,
				lnk.s_up_data[31:0]};
			up_s_reg <= up_m_reg;
		end
	end
	assign {pv_s, pk_s, pd_s, sv_s, sd_s} = up_s_reg[67:0];

	// --------------------------------------------------------------
	// registers and axi4-lite slave
	// --------------------------------------------------------------
	logic aw_got_reg, w_got_reg;
	logic [7:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic [31:0] cmd_reg, cmd_wdata_reg, rdata_reg, pix_p_reg, pix_s_reg, pix_cnt_reg;
	logic [1:0] irq_stat_reg, irq_mask_reg;
	logic busy_reg, go_pend_reg, wr_fire, ar_fire, reply_in, tc_in;
	logic [31:0] rd_val;
	logic rd_ok;

	assign s_axi_awready = ~aw_got_reg & ~s_axi_bvalid;
	assign s_axi_wready = ~w_got_reg & ~s_axi_bvalid;
	assign s_axi_arready = ~s_axi_rvalid;
	assign wr_fire = aw_got_reg & w_got_reg & ~s_axi_bvalid;
	assign ar_fire = s_axi_arvalid & s_axi_arready;
	assign reply_in = rise_en & pv_s & (pk_s == KIND_REPLY);
	assign tc_in = rise_en & pv_s & (pk_s == KIND_TC);

	// address and data taken in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_reg <= 1'b0;
			w_got_reg <= 1'b0;
			awaddr_reg <= 8'h00;
			wdata_reg <= 32'h00000000;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_reg <= 1'b1;
				awaddr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_reg <= 1'b1;
				wdata_reg <= s_axi_wdata;
			end
			if (wr_fire) begin
				aw_got_reg <= 1'b0;
				w_got_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (awaddr_reg == R_CMD || awaddr_reg == R_WDATA ||
					awaddr_reg == R_IRQ_STAT || awaddr_reg == R_IRQ_MASK) ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// software writable registers; byte strobes ignored, whole word
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cmd_reg <= 32'h00000000;
			cmd_wdata_reg <= 32'h00000000;
			irq_mask_reg <= 2'h0;
		end else if (wr_fire) begin
			if (awaddr_reg == R_CMD) begin
				cmd_reg <= wdata_reg & ~(32'h1 << CMD_GO);
			end
			if (awaddr_reg == R_WDATA) begin
				cmd_wdata_reg <= wdata_reg;
			end
			if (awaddr_reg == R_IRQ_MASK) begin
				irq_mask_reg <= wdata_reg[1:0];
			end
		end
	end

	// sticky events: a set in the clearing cycle wins
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_stat_reg <= 2'h0;
		end else begin
			irq_stat_reg <= (irq_stat_reg & ~((wr_fire && awaddr_reg == R_IRQ_STAT) ?
				wdata_reg[1:0] : 2'h0)) | {reply_in, tc_in};
		end
	end
	assign irq = |(irq_stat_reg & irq_mask_reg);

	// read mux
	always_comb begin
		rd_val = 32'h00000000;
		rd_ok = 1'b1;
		unique case (s_axi_araddr)
			R_CMD: rd_val = cmd_reg;
			R_WDATA: rd_val = cmd_wdata_reg;
			R_RDATA: rd_val = rdata_reg;
			R_STATUS: rd_val = {31'h0, busy_reg};
			R_IRQ_STAT: rd_val = {30'h0, irq_stat_reg};
			R_IRQ_MASK: rd_val = {30'h0, irq_mask_reg};
			R_PIX_P: rd_val = pix_p_reg;
			R_PIX_S: rd_val = pix_s_reg;
			R_PIX_CNT: rd_val = pix_cnt_reg;
			default: rd_ok = 1'b0;
		endcase
	end

	// read answer one cycle after address
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= RESP_OKAY;
		end else if (ar_fire) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_val;
			s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// --------------------------------------------------------------
	// command issue on primary link
	// --------------------------------------------------------------
	// commands leave on primary lines only; one outstanding
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			go_pend_reg <= 1'b0;
			busy_reg <= 1'b0;
			lnk.cmd_valid <= 1'b0;
			lnk.cmd_write <= 1'b0;
			lnk.cmd_addr <= 8'h00;
			lnk.cmd_wdata <= 32'h00000000;
		end else begin
			if (wr_fire && awaddr_reg == R_CMD && wdata_reg[CMD_GO] && !busy_reg) begin
				go_pend_reg <= 1'b1;
				busy_reg <= 1'b1;
			end else if (reply_in) begin
				busy_reg <= 1'b0;
			end
			if (fall_en) begin
				lnk.cmd_valid <= go_pend_reg;
				// clearing only a raised flag keeps a go that lands on this edge
				if (go_pend_reg) begin
					go_pend_reg <= 1'b0;
					lnk.cmd_write <= cmd_reg[CMD_WR];
					lnk.cmd_addr <= cmd_reg[CMD_ADDR_LSB +: 8];
					lnk.cmd_wdata <= cmd_wdata_reg;
				end
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rdata_reg <= 32'h00000000;
			pix_p_reg <= 32'h00000000;
			pix_s_reg <= 32'h00000000;
			pix_cnt_reg <= 32'h00000000;
		end else if (rise_en) begin
			if (reply_in) begin
				rdata_reg <= pd_s;
			end
			if (pv_s && pk_s == KIND_SCI) begin
				pix_p_reg <= pd_s;
				pix_cnt_reg <= pix_cnt_reg + 32'h00000001;
			end
			if (sv_s) begin
				pix_s_reg <= sd_s;
			end
		end
	end
endmodule

// file: rtl/flm_fee_end.sv
`timescale 1ns/100ps
module flm_fee_end import flm_pkg::*; #(
	parameter int NUM_PIX = 64,
	parameter int FULL_LOAD_CYC_P = FULL_LOAD_CYC
)(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// link to processing unit
	flm_link_if.fee lnk,
	// sync pulse from ancillary unit
	input wire logic sync_in,
	// video converter pixels, one pair per slot except in mode 5
	input wire logic [15:0] vid_a,
	input wire logic [15:0] vid_b,
	// housekeeping converters
	input wire logic [15:0] hires_adc,
	input wire logic [11:0] std_adc,
	// analog and converter control
	output logic analog_pwr_full,
	output logic [2:0] conv_cfg,
	output logic [2:0] hires_sel,
	output logic hires_excite,
	output logic amp_zero,
	output logic [3:0] std_sel
);
	// --------------------------------------------------------------
	// pin synchronisers and edge finders
	// --------------------------------------------------------------
	localparam int PW = 104;
	logic [PW-1:0] pin_m_reg;
	logic [PW-1:0] pin_s_reg;
	logic lclk_s, cmdv_s, cmdw_s, sync_s;
	logic [7:0] cmda_s;
	logic [31:0] cmdd_s;
	logic [15:0] vida_s, vidb_s, hires_s;
	logic [11:0] std_s;
	logic lclk_d_reg, sync_d_reg;
	logic rise_en, fall_en, sync_end;

	// two flops on everything from outside
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_m_reg <= '0;
			pin_s_reg <= '0;
		end else begin
			pin_m_reg <= {lnk.link_clk, lnk.cmd_valid, lnk.cmd_write, lnk.cmd_addr,
				lnk.cmd_wdata, sync_in, vid_a, vid_b, hires_adc, std_adc};
			pin_s_reg <= pin_m_reg;
		end
	end
	assign {lclk_s, cmdv_s, cmdw_s, cmda_s, cmdd_s, sync_s, vida_s, vidb_s, hires_s,
		std_s} = pin_s_reg;

	// edge history
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lclk_d_reg <= 1'b0;
			sync_d_reg <= 1'b0;
		end else begin
			lclk_d_reg <= lclk_s;
			sync_d_reg <= sync_s;
		end
	end
	assign rise_en = lclk_s & ~lclk_d_reg; // command sample point
	assign fall_en = ~lclk_s & lclk_d_reg; // upstream launch point
	assign sync_end = ~sync_s & sync_d_reg;

	// --------------------------------------------------------------
	// sync pulse timing and cycle phase
	// --------------------------------------------------------------
	logic [15:0] sw_cnt_reg;
	logic [1:0] phase_reg;
	logic long_pulse;

	// pulse width counter, saturating
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sw_cnt_reg <= 16'h0000;
		end else if (sync_s) begin
			if (sw_cnt_reg != 16'hFFFF) begin
				sw_cnt_reg <= sw_cnt_reg + 16'h0001;
			end
		end else begin
			sw_cnt_reg <= 16'h0000;
		end
	end
	assign long_pulse = sw_cnt_reg >= 16'(LONG_CYC);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			phase_reg <= 2'h0;
		end else if (sync_end) begin
			phase_reg <= long_pulse ? 2'h0 : phase_reg + 2'h1;
		end
	end

	// --------------------------------------------------------------
	// command decoding and memory map
	// --------------------------------------------------------------
	logic [31:0] ctrl_reg;
	logic [MODE_W-1:0] mode_reg;
	logic [15:0] img_cnt_reg;
	logic [15:0] hires_mem [N_HIRES];
	logic [11:0] std_mem [N_STD];
	logic reply_pend_reg;
	logic [31:0] reply_data_reg;
	logic [31:0] rd_word;
	logic cmd_take, running;
	flm_op_t op;
	flm_rd_t rd_state;

	// commands only arrive on primary lines
	assign cmd_take = rise_en & cmdv_s;
	assign op = flm_op_t'(ctrl_reg[CTRL_OP_LSB +: 2]);
	assign running = (op == OP_RUN); // illegal op code acts as stop

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_reg <= CTRL_RST;
		end else if (cmd_take && cmdw_s && cmda_s == ADDR_CTRL) begin
			ctrl_reg <= cmdd_s;
		end
	end

	// every mode code accepted, none refused
	// mode applied only at cycle start
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_reg <= '0;
		end else if (sync_end && long_pulse) begin
			mode_reg <= ctrl_reg[CTRL_MODE_LSB +: MODE_W];
		end
	end

	always_comb begin
		rd_word = 32'h00000000;
		if (cmda_s == ADDR_CTRL) begin
			rd_word = ctrl_reg;
		end else if (cmda_s == ADDR_STATUS) begin
			rd_word = {22'h0, rd_state, phase_reg, mode_reg, ctrl_reg[CTRL_OP_LSB +: 2]};
		end else if (cmda_s == ADDR_IMG) begin
			rd_word = {16'h0000, img_cnt_reg};
		end else if (cmda_s[7:3] == ADDR_HIRES[7:3]) begin
			rd_word = {16'h0000, hires_mem[cmda_s[2:0]]};
		end else if (cmda_s[7:4] == ADDR_STD[7:4]) begin
			rd_word = {20'h00000, std_mem[cmda_s[3:0]]};
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			reply_pend_reg <= 1'b0;
			reply_data_reg <= 32'h00000000;
		end else if (cmd_take) begin
			reply_pend_reg <= 1'b1;
			reply_data_reg <= cmdw_s ? 32'h00000000 : rd_word;
		end else if (fall_en) begin
			reply_pend_reg <= 1'b0;
		end
	end

	// --------------------------------------------------------------
	// readout and precise housekeeping sequence
	// --------------------------------------------------------------
	logic [15:0] pix_cnt_reg;
	logic [15:0] tmr_reg;
	logic hk_idx_reg;
	logic single, slot_free, last_slot, meas_done;

	assign single = (mode_reg == 3'd5);
	assign slot_free = fall_en & ~reply_pend_reg; // replies take priority
	assign last_slot = single ? (pix_cnt_reg == 16'(NUM_PIX - 1)) :
		(pix_cnt_reg == 16'(NUM_PIX / 2 - 1));
	assign meas_done = (rd_state == RD_MEAS) && (tmr_reg == 16'h0000);

	// one detector image per sync period
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_state <= RD_IDLE;
			pix_cnt_reg <= 16'h0000;
			tmr_reg <= 16'h0000;
			hk_idx_reg <= 1'b0;
		end else begin
			unique case (rd_state)
				RD_IDLE: begin
					pix_cnt_reg <= 16'h0000;
					hk_idx_reg <= 1'b0;
					tmr_reg <= 16'(ZERO_CYC - 1);
					if (sync_end) begin
						rd_state <= running ? RD_READ : RD_ZERO;
					end
				end
				RD_READ: begin
					if (!running) begin
						rd_state <= RD_ZERO;
					end else if (slot_free) begin
						pix_cnt_reg <= pix_cnt_reg + 16'h0001;
						if (last_slot) begin
							rd_state <= RD_MARK;
						end
					end
				end
				RD_MARK: begin
					if (slot_free) begin
						rd_state <= RD_ZERO;
					end
				end
				RD_ZERO: begin
					if (tmr_reg == 16'h0000) begin
						rd_state <= RD_MEAS;
						tmr_reg <= 16'(SETTLE_CYC - 1);
					end else begin
						tmr_reg <= tmr_reg - 16'h0001;
					end
				end
				RD_MEAS: begin
					if (tmr_reg != 16'h0000) begin
						tmr_reg <= tmr_reg - 16'h0001;
					end else if (hk_idx_reg == 1'(HIRES_PER_PHASE - 1)) begin
						rd_state <= RD_IDLE;
					end else begin
						hk_idx_reg <= hk_idx_reg + 1'b1;
						tmr_reg <= 16'(SETTLE_CYC - 1);
					end
				end
				default: rd_state <= RD_IDLE;
			endcase
		end
	end

	// one sensor selected, excited while measured
	assign hires_sel = {phase_reg, hk_idx_reg};
	assign hires_excite = (rd_state == RD_MEAS);
	assign amp_zero = (rd_state == RD_ZERO);

	always_ff @(posedge aclk) begin
		if (meas_done) begin
			hires_mem[hires_sel] <= hires_s;
		end
	end

	// images completed
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			img_cnt_reg <= 16'h0000;
		end else if (rd_state == RD_MARK && slot_free) begin
			img_cnt_reg <= img_cnt_reg + 16'h0001;
		end
	end

	// --------------------------------------------------------------
	// upstream word launch
	// --------------------------------------------------------------
	// words change only at link falls so the far end sees them stable
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lnk.p_up_valid <= 1'b0;
			lnk.p_up_kind <= 2'h0;
			lnk.p_up_data <= 32'h00000000;
			lnk.s_up_valid <= 1'b0;
			lnk.s_up_data <= 32'h00000000;
		end else if (fall_en) begin
			lnk.p_up_valid <= 1'b0;
			lnk.s_up_valid <= 1'b0;
			if (reply_pend_reg) begin
				lnk.p_up_valid <= 1'b1;
				lnk.p_up_kind <= KIND_REPLY;
				lnk.p_up_data <= reply_data_reg;
			end else if (rd_state == RD_READ && running) begin
				lnk.p_up_valid <= 1'b1;
				lnk.p_up_kind <= KIND_SCI;
				lnk.p_up_data <= {pix_cnt_reg, (single && pix_cnt_reg[0]) ? vidb_s : vida_s};
				lnk.s_up_valid <= ~single;
				lnk.s_up_data <= {pix_cnt_reg, vidb_s};
			end else if (rd_state == RD_MARK) begin
				lnk.p_up_valid <= 1'b1;
				lnk.p_up_kind <= KIND_TC;
				lnk.p_up_data <= {16'h0000, img_cnt_reg};
			end
		end
	end

	// --------------------------------------------------------------
	// standard monitors, power and converter setup
	// --------------------------------------------------------------
	logic [15:0] std_tmr_reg;
	logic [31:0] pwr_cnt_reg;

	// free-running scan, not tied to readout
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			std_tmr_reg <= 16'h0000;
			std_sel <= 4'h0;
		end else if (std_tmr_reg == 16'(STD_CYC - 1)) begin
			std_tmr_reg <= 16'h0000;
			std_sel <= std_sel + 4'h1;
		end else begin
			std_tmr_reg <= std_tmr_reg + 16'h0001;
		end
	end

	// result stored before channel moves on
	always_ff @(posedge aclk) begin
		if (std_tmr_reg == 16'(STD_CYC - 1)) begin
			std_mem[std_sel] <= std_s;
		end
	end

	// full load window after each sync while running
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pwr_cnt_reg <= 32'h00000000;
		end else if (sync_end && running) begin
			pwr_cnt_reg <= 32'(FULL_LOAD_CYC_P);
		end else if (pwr_cnt_reg != 32'h00000000) begin
			pwr_cnt_reg <= pwr_cnt_reg - 32'h00000001;
		end
	end
	assign analog_pwr_full = (pwr_cnt_reg != 32'h00000000);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			conv_cfg <= 3'h0;
		end else begin
			conv_cfg <= flm_conv_cfg(mode_reg);
		end
	end
endmodule

// file: rtl/flm_link_if.sv
`timescale 1ns/100ps
interface flm_link_if;
	// link clock, made by the processing unit
	logic link_clk;
	// primary downstream: commands
	logic cmd_valid;
	logic cmd_write;
	logic [7:0] cmd_addr;
	logic [31:0] cmd_wdata;
	// primary upstream
	logic p_up_valid;
	logic [1:0] p_up_kind;
	logic [31:0] p_up_data;
	// secondary upstream: science only
	logic s_up_valid;
	logic [31:0] s_up_data;

	modport fee (
		input link_clk, cmd_valid, cmd_write, cmd_addr, cmd_wdata,
		output p_up_valid, p_up_kind, p_up_data, s_up_valid, s_up_data
	);
	modport dpu (
		output link_clk, cmd_valid, cmd_write, cmd_addr, cmd_wdata,
		input p_up_valid, p_up_kind, p_up_data, s_up_valid, s_up_data
	);
endinterface

// file: rtl/flm_pkg.sv
package flm_pkg;
	// --------------------------------------------------------------
	// clock and timing
	// --------------------------------------------------------------
	localparam int CLK_NS = 40;
	localparam int LINK_PERIOD_NS = 320;
	localparam int LINK_DIV = LINK_PERIOD_NS / CLK_NS;
	localparam int LINK_HALF = LINK_DIV / 2;
	localparam int SYNC_PERIOD_MS = 6250;
	localparam int CYCLE_MS = 25000;
	localparam int CYCLE_PHASES = CYCLE_MS / SYNC_PERIOD_MS;
	localparam int FULL_LOAD_MS = 4000;
	localparam int FULL_LOAD_CYC = int'(64'(FULL_LOAD_MS) * 64'd1000000 / 64'(CLK_NS));
	localparam int LONG_PULSE_US = 10;
	localparam int LONG_CYC = (LONG_PULSE_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int ZERO_US = 20;
	localparam int ZERO_CYC = (ZERO_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int SETTLE_US = 100;
	localparam int SETTLE_CYC = (SETTLE_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int STD_US = 10;
	localparam int STD_CYC = (STD_US * 1000 + CLK_NS - 1) / CLK_NS;
	// --------------------------------------------------------------
	// front-end memory map (word addresses)
	// --------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h01;
	localparam logic [7:0] ADDR_IMG = 8'h02;
	localparam logic [7:0] ADDR_HIRES = 8'h10;
	localparam logic [7:0] ADDR_STD = 8'h20;
	localparam int CTRL_OP_LSB = 0;
	localparam int CTRL_MODE_LSB = 2;
	localparam logic [31:0] CTRL_RST = 32'h00000000;
	localparam int MODE_W = 3;
	localparam int N_HIRES = 8;
	localparam int N_STD = 16;
	localparam int HIRES_PER_PHASE = N_HIRES / CYCLE_PHASES;
	// --------------------------------------------------------------
	// upstream word kinds
	// --------------------------------------------------------------
	localparam logic [1:0] KIND_REPLY = 2'h1;
	localparam logic [1:0] KIND_SCI = 2'h2;
	localparam logic [1:0] KIND_TC = 2'h3;
	// --------------------------------------------------------------
	// controller registers (byte addresses)
	// --------------------------------------------------------------
	localparam logic [7:0] R_CMD = 8'h00;
	localparam logic [7:0] R_WDATA = 8'h04;
	localparam logic [7:0] R_RDATA = 8'h08;
	localparam logic [7:0] R_STATUS = 8'h0C;
	localparam logic [7:0] R_IRQ_STAT = 8'h10;
	localparam logic [7:0] R_IRQ_MASK = 8'h14;
	localparam logic [7:0] R_PIX_P = 8'h18;
	localparam logic [7:0] R_PIX_S = 8'h1C;
	localparam logic [7:0] R_PIX_CNT = 8'h20;
	localparam int CMD_GO = 0;
	localparam int CMD_WR = 1;
	localparam int CMD_ADDR_LSB = 8;
	localparam int IRQ_EOI = 0;
	localparam int IRQ_REPLY = 1;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		OP_STOP = 2'b00,
		OP_TEST = 2'b01,
		OP_RUN = 2'b10
	} flm_op_t;

	typedef enum logic [2:0] {
		RD_IDLE = 3'b000,
		RD_READ = 3'b001,
		RD_MARK = 3'b010,
		RD_ZERO = 3'b011,
		RD_MEAS = 3'b100
	} flm_rd_t;

	// converter setup per mode: {rate_4m, pingpong, dual}
	function automatic logic [2:0] flm_conv_cfg(input logic [MODE_W-1:0] m);
		case (m)
			3'd1, 3'd5: flm_conv_cfg = 3'b000;
			3'd2, 3'd6: flm_conv_cfg = 3'b111;
			3'd7: flm_conv_cfg = 3'b110;
			default: flm_conv_cfg = 3'b101;
		endcase
	endfunction
endpackage
